// >>> rtl/rsa_pkg.sv
package rsa_pkg;

  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CMD      = 8'h04;
  localparam logic [7:0] ADDR_LRV      = 8'h08;
  localparam logic [7:0] ADDR_URV      = 8'h0c;
  localparam logic [7:0] ADDR_CAL_LO   = 8'h10;
  localparam logic [7:0] ADDR_CAL_HI   = 8'h14;
  localparam logic [7:0] ADDR_MIN_SPAN = 8'h18;
  localparam logic [7:0] ADDR_DAMP     = 8'h1c;
  localparam logic [7:0] ADDR_ZERO     = 8'h20;
  localparam logic [7:0] ADDR_GAIN     = 8'h24;
  localparam logic [7:0] ADDR_ALM_CFG  = 8'h28;
  localparam logic [7:0] ADDR_ALM1_LIM = 8'h2c;
  localparam logic [7:0] ADDR_ALM2_LIM = 8'h30;
  localparam logic [7:0] ADDR_STATUS   = 8'h34;
  localparam logic [7:0] ADDR_PV       = 8'h38;
  localparam logic [7:0] ADDR_PCT      = 8'h3c;
  localparam logic [7:0] ADDR_LOOP     = 8'h40;
  localparam logic [7:0] ADDR_CUR_TRIM = 8'h44;
  localparam logic [7:0] ADDR_TEMP_COR = 8'h48;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CTRL_PID      = 0;
  localparam int CTRL_DUAL     = 1;
  localparam int CTRL_REF_LO   = 2;
  localparam int CTRL_SEL1_LSB = 4;
  localparam int CTRL_SEL2_LSB = 8;
  localparam int CMD_ACK       = 0;
  localparam int CMD_FACTORY   = 1;
  localparam int CMD_REF_LO    = 2;
  localparam int CMD_REF_HI    = 3;
  localparam int ALM_BURN_EN   = 0;
  localparam int ALM1_ACT_LSB  = 2;
  localparam int ALM2_ACT_LSB  = 4;

  // ***************************************************************
  // values and counts
  // ***************************************************************
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] URV_RESET    = 32'h0001_0000;
  localparam logic [31:0] CAL_HI_RESET = 32'h7fff_ffff;
  localparam logic [31:0] CAL_LO_RESET = 32'h8000_0000;
  localparam logic [31:0] SPAN_RESET   = 32'h0000_0100;
  localparam logic [15:0] PCT_FULL     = 16'h2710;   // 100.00 percent
  localparam logic [15:0] LOOP_MIN_UA  = 16'h0fa0;   // 4000 uA
  localparam logic [15:0] LOOP_SPAN_UA = 16'h3e80;   // 16000 uA
  localparam int          CLK_HZ       = 100_000_000;
  localparam int          DAMP_MAX_S   = 32;
  localparam int          DAMP_TICK_MS = 1;
  localparam int          TICK_CYCLES  = CLK_HZ / 1000 * DAMP_TICK_MS;
  localparam logic [5:0]  DAMP_MAX     = 6'h20;

  typedef enum logic [3:0] {
    RSA_MV_CURRENT, RSA_MV_OUT_PCT, RSA_MV_PV, RSA_MV_TEMP, RSA_MV_PV_PCT,
    RSA_MV_SP_PCT, RSA_MV_SP, RSA_MV_TIME, RSA_MV_DEV_PCT, RSA_MV_NONE
  } rsa_var_t;

  typedef enum logic [1:0] {RSA_ACT_OFF, RSA_ACT_LOW, RSA_ACT_HIGH} rsa_act_t;

endpackage

// >>> rtl/rsa_range_alarm.sv
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
// Behaviour
// R1 - display alternates between two selected variables
// R2 - same or none second selection: steady
// R3 - controller-only variables need controller mode
// R4 - transmitter: lower 4 mA, upper 20 mA
// R5 - controller: lower 0%, upper 100%
// R6 - non-reference write leaves other value
// R7 - range values within calibration limits
// R8 - range difference must exceed minimum span
// R9 - reversed range gives falling output
// R10 - operator reverses via span, upper, lower
// R11 - referenced lower keeps span, takes input
// R12 - damping time zero to thirty-two seconds
// R13 - converter 0% min, 100% max, trimmed
// R14 - zero trim leaves gain trim unchanged
// R15 - factory trim restores stored corrections
// R16 - dual-sensor modes refuse gain trim
// R17 - three alarms, 1 and 2 configurable
// R18 - alarm zero is enableable burnout
// R19 - action low, high or off
// R20 - low below limit, high above limit
// R21 - acknowledge recognises; ack flag clears
// R22 - percent is (in-lower)/(upper-lower)
// R23 - damping is first-order low-pass filter
module rsa_range_alarm #(
  parameter int          TICK     = rsa_pkg::TICK_CYCLES,
  parameter logic [31:0] FAC_ZERO = 32'h0000_0000,
  parameter logic [31:0] FAC_GAIN = 32'h0001_0000,
  parameter logic [31:0] FAC_TEMP = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // measurement
  input  wire logic [31:0] sensor_in,
  input  wire logic        burnout,
  // outputs
  output logic [15:0]      loop_current_reading,
  output logic [3:0]       display_var,
  output logic [2:0]       alarm_active,
  output logic             ack_pending
);
  import rsa_pkg::*;

  // ***************************************************************
  // configuration and run-time state
  // ***************************************************************
  logic [31:0] ctrl, lrv, urv, cal_lo, cal_hi, min_span, zero_tr, gain_tr;
  logic [31:0] temp_cor, cur_trim, alm_cfg, alm1_lim, alm2_lim;
  logic [5:0]  damp;
  logic [31:0] pv, pv_f;
  logic [15:0] pct;
  logic [2:0]  pend;
  logic        rejected;

  function automatic logic signed [32:0] sdiff(input logic [31:0] a, input logic [31:0] b);
    return 33'(signed'(a)) - 33'(signed'(b));
  endfunction

  function automatic logic signed [32:0] sabs(input logic signed [32:0] a);
    return a < 0 ? -a : a;
  endfunction

  // value in limits and span large enough
  function automatic logic range_ok(input logic [31:0] lo, input logic [31:0] hi,
                                    input logic [31:0] cl, input logic [31:0] ch,
                                    input logic [31:0] sp);
    return $signed(lo) >= $signed(cl) && $signed(lo) <= $signed(ch) &&
           $signed(hi) >= $signed(cl) && $signed(hi) <= $signed(ch) &&
           sabs(sdiff(hi, lo)) > 33'(sp);
  endfunction

  // ***************************************************************
  // bus slave: single write and single read in flight
  // ***************************************************************
  logic       aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  wire        wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  wire [31:0] next_word = w_data;
  wire        wr_lrv   = wr_fire && aw_addr == ADDR_LRV;
  wire        wr_urv   = wr_fire && aw_addr == ADDR_URV;
  wire        wr_gain  = wr_fire && aw_addr == ADDR_GAIN;
  wire        wr_cmd   = wr_fire && aw_addr == ADDR_CMD;
  wire        cmd_fac  = wr_cmd && next_word[CMD_FACTORY];
  wire        cmd_ack  = wr_cmd && next_word[CMD_ACK];
  wire        cmd_rlo  = wr_cmd && next_word[CMD_REF_LO];
  wire        cmd_rhi  = wr_cmd && next_word[CMD_REF_HI];
  wire [31:0] span     = 32'(sdiff(urv, lrv));
  wire [31:0] ref_urv  = pv + span;
  wire        ok_lrv   = range_ok(next_word, urv, cal_lo, cal_hi, min_span);   // R7 R8
  wire        ok_urv   = range_ok(lrv, next_word, cal_lo, cal_hi, min_span);   // R7 R8
  wire        ok_rlo   = range_ok(pv, ref_urv, cal_lo, cal_hi, min_span);
  wire        ok_rhi   = range_ok(lrv, pv, cal_lo, cal_hi, min_span);
  wire        bad_wr   = (wr_lrv && !ok_lrv) || (wr_urv && !ok_urv) ||
                         (wr_gain && ctrl[CTRL_DUAL]) ||                       // R16
                         (cmd_rlo && !ok_rlo) || (cmd_rhi && !ok_rhi);

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= bad_wr ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold && !s_axi_bvalid && !rst;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid && !rst;

  // ***************************************************************
  // register writes
  // ***************************************************************
  // display selections that need controller mode fall back to current
  wire [3:0] sel_in1 = next_word[CTRL_SEL1_LSB +: 4];
  wire [3:0] sel_in2 = next_word[CTRL_SEL2_LSB +: 4];
  function automatic logic pid_only(input logic [3:0] v);
    return v inside {RSA_MV_OUT_PCT, RSA_MV_SP_PCT, RSA_MV_SP, RSA_MV_TIME, RSA_MV_DEV_PCT};
  endfunction
  wire [31:0] next_ctrl = {next_word[31:12],
                           (pid_only(sel_in2) && !next_word[CTRL_PID]) ? 4'h0 : sel_in2, // R3
                           (pid_only(sel_in1) && !next_word[CTRL_PID]) ? 4'h0 : sel_in1, // R3
                           next_word[3:0]};
  wire       wr_ok = wr_fire && !bad_wr;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      lrv <= 32'h0000_0000;
      urv <= URV_RESET;
      cal_lo <= CAL_LO_RESET;
      cal_hi <= CAL_HI_RESET;
      min_span <= SPAN_RESET;
      damp <= 6'h00;
      zero_tr <= 32'h0000_0000;
      gain_tr <= 32'h0001_0000;
      temp_cor <= 32'h0000_0000;
      cur_trim <= 32'h0000_0000;
      alm_cfg <= 32'h0000_0000;
      alm1_lim <= 32'h0000_0000;
      alm2_lim <= 32'h0000_0000;
      rejected <= 1'b0;
    end else begin
      if (wr_fire) rejected <= bad_wr;
      if (wr_ok) begin
        unique case (aw_addr)
          ADDR_CTRL:     ctrl <= next_ctrl;
          ADDR_LRV:      lrv <= next_word;               // R6
          ADDR_URV:      urv <= next_word;               // R6 R9
          ADDR_CAL_LO:   cal_lo <= next_word;
          ADDR_CAL_HI:   cal_hi <= next_word;
          ADDR_MIN_SPAN: min_span <= next_word;
          ADDR_DAMP:     damp <= next_word > 32'(DAMP_MAX) ? DAMP_MAX : next_word[5:0]; // R12
          ADDR_ZERO:     zero_tr <= next_word;           // R14
          ADDR_GAIN:     gain_tr <= next_word;
          ADDR_CUR_TRIM: cur_trim <= next_word;          // R13
          ADDR_TEMP_COR: temp_cor <= next_word;
          ADDR_ALM_CFG:  alm_cfg <= next_word;
          ADDR_ALM1_LIM: alm1_lim <= next_word;
          ADDR_ALM2_LIM: alm2_lim <= next_word;
          default: ;
        endcase
        if (cmd_fac) begin
          zero_tr <= FAC_ZERO;                           // R15
          gain_tr <= FAC_GAIN;                           // R15
          temp_cor <= FAC_TEMP;                          // R15
        end
        if (cmd_rlo) begin
          lrv <= pv;                                     // R11
          urv <= ref_urv;                                // R11
        end
        if (cmd_rhi) urv <= pv;
      end
    end
  end

  // ***************************************************************
  // trimmed input, percent, damping
  // ***************************************************************
  wire signed [63:0] trim_prod = 64'(signed'(sensor_in) - signed'(zero_tr)) *
                                 64'(signed'(gain_tr));
  wire signed [63:0] pct_num   = 64'(sdiff(pv_f, lrv)) * 64'(PCT_FULL);
  // a signed zero keeps the divide signed, which the reversed range needs
  wire signed [63:0] pct_q     = span == 32'h0 ? 64'sh0 : pct_num / 64'(signed'(span)); // R22 R9
  wire [15:0]  next_pct = pct_q < 0 ? 16'h0000 : pct_q > 64'(PCT_FULL) ? PCT_FULL :
                          16'(pct_q);                    // R5
  logic [31:0] tick_cnt;
  wire         tick = tick_cnt == 32'(TICK - 1);
  // alpha = tick / tau ; tau in ms is damp*1000, done as shift-free divide
  wire signed [32:0] pv_err = sdiff(pv, pv_f);
  wire [31:0]  damp_ms = 32'(damp) * 32'd1000;
  wire [31:0]  next_pv_f = damp == 6'h00 ? pv :
                           pv_f + 32'(pv_err / 33'(signed'(damp_ms)));      // R23

  always_ff @(posedge clk) begin
    if (rst) begin
      pv <= 32'h0000_0000;
      pv_f <= 32'h0000_0000;
      pct <= 16'h0000;
      tick_cnt <= 32'h0000_0000;
    end else begin
      pv <= 32'(trim_prod >>> 16);
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h1;
      if (tick || damp == 6'h00) pv_f <= next_pv_f;      // R12 R23
      pct <= next_pct;
    end
  end

  // ***************************************************************
  // loop current
  // ***************************************************************
  wire [31:0] next_loop = 32'(LOOP_MIN_UA) + 32'(pct) * 32'(LOOP_SPAN_UA) / 32'(PCT_FULL) +
                          cur_trim;
  always_ff @(posedge clk) begin
    if (rst) loop_current_reading <= LOOP_MIN_UA;
    else loop_current_reading <= next_loop[15:0];      // R4 R13
  end

  // ***************************************************************
  // display alternation
  // ***************************************************************
  wire [3:0] sel1 = ctrl[CTRL_SEL1_LSB +: 4];
  wire [3:0] sel2 = ctrl[CTRL_SEL2_LSB +: 4];
  wire       steady = sel1 == sel2 || sel2 == 4'(RSA_MV_NONE);   // R2
  logic [11:0] disp_cnt;
  logic        disp_phase;
  always_ff @(posedge clk) begin
    if (rst) begin
      disp_cnt <= 12'h000;
      disp_phase <= 1'b0;
      display_var <= 4'h0;
    end else begin
      if (tick) disp_cnt <= disp_cnt + 12'h001;
      if (tick && disp_cnt == 12'hfff) disp_phase <= !disp_phase && !steady; // R1
      display_var <= (disp_phase && !steady) ? sel2 : sel1;               // R1 R2
    end
  end

  // ***************************************************************
  // alarms
  // ***************************************************************
  function automatic logic trip(input logic [1:0] act, input logic [31:0] lim,
                                input logic [31:0] v);
    return (act == 2'(RSA_ACT_LOW)  && $signed(v) < $signed(lim)) ||      // R20
           (act == 2'(RSA_ACT_HIGH) && $signed(v) > $signed(lim));        // R19
  endfunction
  logic burn_m, burnout_s;
  wire [2:0] next_alarm = {trip(alm_cfg[ALM2_ACT_LSB +: 2], alm2_lim, pv_f),
                           trip(alm_cfg[ALM1_ACT_LSB +: 2], alm1_lim, pv_f),
                           burnout_s && alm_cfg[ALM_BURN_EN]};               // R17 R18
  always_ff @(posedge clk) begin
    if (rst) begin
      burn_m <= 1'b0;
      burnout_s <= 1'b0;
      alarm_active <= 3'h0;
      pend <= 3'h0;
      ack_pending <= 1'b0;
    end else begin
      burn_m <= burnout;
      burnout_s <= burn_m;
      alarm_active <= next_alarm;
      // a new rising alarm wins over a simultaneous acknowledge
      pend <= ((wr_ok && cmd_ack) ? 3'h0 : pend) | (next_alarm & ~alarm_active); // R21
      ack_pending <= |(((wr_ok && cmd_ack) ? 3'h0 : pend) | (next_alarm & ~alarm_active));
    end
  end

  // ***************************************************************
  // read channel
  // ***************************************************************
  wire [31:0] status = {27'h0, rejected, ack_pending, alarm_active};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      ADDR_CTRL:     rd_mux = ctrl;
      ADDR_LRV:      rd_mux = lrv;
      ADDR_URV:      rd_mux = urv;
      ADDR_CAL_LO:   rd_mux = cal_lo;
      ADDR_CAL_HI:   rd_mux = cal_hi;
      ADDR_MIN_SPAN: rd_mux = min_span;
      ADDR_DAMP:     rd_mux = 32'(damp);
      ADDR_ZERO:     rd_mux = zero_tr;
      ADDR_GAIN:     rd_mux = gain_tr;
      ADDR_ALM_CFG:  rd_mux = alm_cfg;
      ADDR_ALM1_LIM: rd_mux = alm1_lim;
      ADDR_ALM2_LIM: rd_mux = alm2_lim;
      ADDR_STATUS:   rd_mux = status;
      ADDR_PV:       rd_mux = pv_f;
      ADDR_PCT:      rd_mux = 32'(pct);
      ADDR_LOOP:     rd_mux = 32'(loop_current_reading);
      ADDR_CUR_TRIM: rd_mux = cur_trim;
      ADDR_TEMP_COR: rd_mux = temp_cor;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_hit = s_axi_araddr <= ADDR_TEMP_COR && s_axi_araddr[1:0] == 2'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid && !rst;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_steady_display: assert property (@(posedge clk) disable iff (rst)
    steady ##1 $stable(ctrl) |-> display_var == sel1)
    else $error("display alternates while steady"); // R2
  a_low_alarm_trip: assert property (@(posedge clk) disable iff (rst)
    alm_cfg[ALM1_ACT_LSB +: 2] == 2'(RSA_ACT_LOW) && $signed(pv_f) < $signed(alm1_lim)
    |=> alarm_active[1]) else $error("low alarm missed"); // R20
  a_off_alarm_quiet: assert property (@(posedge clk) disable iff (rst)
    alm_cfg[ALM2_ACT_LSB +: 2] == 2'(RSA_ACT_OFF) |=> !alarm_active[2])
    else $error("disabled alarm tripped"); // R19
  a_gain_refused: assert property (@(posedge clk) disable iff (rst)
    wr_gain && ctrl[CTRL_DUAL] |=> $stable(gain_tr) && s_axi_bresp == 2'h2)
    else $error("gain trim taken in dual mode"); // R16
  a_zero_keeps_gain: assert property (@(posedge clk) disable iff (rst)
    wr_fire && aw_addr == ADDR_ZERO |=> $stable(gain_tr))
    else $error("zero trim changed gain"); // R14
  a_factory_restore: assert property (@(posedge clk) disable iff (rst)
    wr_ok && cmd_fac |=> zero_tr == FAC_ZERO && gain_tr == FAC_GAIN)
    else $error("factory trim not restored"); // R15
  a_lrv_keeps_urv: assert property (@(posedge clk) disable iff (rst)
    wr_lrv |=> $stable(urv)) else $error("lower write moved upper"); // R6
  a_damp_bound: assert property (@(posedge clk) disable iff (rst)
    damp <= DAMP_MAX) else $error("damping above maximum"); // R12
  a_ack_clears: assert property (@(posedge clk) disable iff (rst)
    wr_ok && cmd_ack && next_alarm == alarm_active |=> !ack_pending)
    else $error("ack did not clear"); // R21

endmodule

// >>> bench/rsa_cfg_master.sv
`timescale 1ns/10ps
// ****************************************
// configurator model: axi4-lite master
// ****************************************
module rsa_cfg_master (
  // clock
  input  wire logic        clk,
  // write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
  end

  // released payload is inverted so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
  endtask
endmodule

// >>> bench/test_range_scaling_and_alarm.sv
`timescale 1ns/10ps
module test_range_scaling_and_alarm;
  import rsa_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb, display_var;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] sensor_in = 32'h0;
  logic        burnout = 1'b0;
  logic [15:0] loop_current_reading, seen;
  logic [2:0]  alarm_active;
  logic        ack_pending;
  logic [31:0] dctl [3] = '{32'h0220, 32'h0920, 32'h0020};
  logic [15:0] dmask [3] = '{16'h0004, 16'h0004, 16'h0005};
  int          err_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          lrv, urv, v;

  always #5 clk = ~clk;

  rsa_range_alarm #(.TICK(4)) u_rsa_range_alarm (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sensor_in, .burnout, .loop_current_reading, .display_var, .alarm_active, .ack_pending);
  rsa_cfg_master u_rsa_cfg_master (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic stop_test;
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the display test alone needs some 54000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    u_rsa_cfg_master.wr(a, d, rs);
    check(rs, er);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    u_rsa_cfg_master.rd(a, rv, rs);
    check(rv, e);
  endtask

  // poll until the value shows, bounded; the last read is the comparison
  task automatic poll(input logic [7:0] a, input logic [31:0] e);
    for (int i = 0; i < 300; i++) begin
      u_rsa_cfg_master.rd(a, rv, rs);
      if (rv === e) break;
    end
    check(rv, e);
  endtask

  // model: percent is linear in the input between the two range values
  task automatic settle(input int x, input bit xmtr);
    int p;
    p = (x - lrv) * 10000 / (urv - lrv);
    @(posedge clk);
    sensor_in <= x;
    poll(ADDR_PCT, p);
    @(negedge clk);
    if (xmtr) check(loop_current_reading, 4000 + p * 16000 / 10000);
  endtask

  initial begin
    v = $urandom(54158);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    check(loop_current_reading, 32'h0fa0);
    rdchk(ADDR_URV, URV_RESET);
    rdchk(ADDR_MIN_SPAN, SPAN_RESET);
    u_rsa_cfg_master.rd(8'hfc, rv, rs);
    check(rs, 2'h2);
    lrv = 0;
    urv = 10000;
    wr(ADDR_URV, 32'h2710, 2'h0);
    rdchk(ADDR_LRV, 32'h0);
    wr(ADDR_DAMP, 32'h0, 2'h0);
    settle(0, 1);
    settle(10000, 1);
    repeat (4) settle(($urandom % 2001) * 5, 1);
    wr(ADDR_LRV, 32'(10000 - 256), 2'h2);
    wr(ADDR_CAL_HI, 32'h4e20, 2'h0);
    wr(ADDR_URV, 32'h4e21, 2'h2);
    wr(ADDR_CAL_LO, -32'sd5000, 2'h0);
    wr(ADDR_LRV, -32'sd5001, 2'h2);
    rdchk(ADDR_LRV, 32'h0);
    wr(ADDR_LRV, 32'(10000 - 300), 2'h0);
    wr(ADDR_URV, 32'h0, 2'h0);
    wr(ADDR_LRV, 32'h2710, 2'h0);
    lrv = 10000;
    urv = 0;
    settle(2500, 1);
    @(posedge clk);
    sensor_in <= 12000;
    poll(ADDR_PV, 32'd12000);
    wr(ADDR_CMD, 32'h4, 2'h0);
    rdchk(ADDR_URV, 32'd2000);
    lrv = 12000;
    urv = 2000;
    settle(7000, 1);
    wr(ADDR_DAMP, 32'd40, 2'h0);
    rdchk(ADDR_DAMP, 32'd32);
    wr(ADDR_DAMP, 32'h1, 2'h0);
    @(posedge clk);
    sensor_in <= 12000;
    repeat (100) @(posedge clk);
    check(loop_current_reading > 4000 && loop_current_reading < 12000, 1);
    wr(ADDR_DAMP, 32'h0, 2'h0);
    settle(12000, 1);
    wr(ADDR_CUR_TRIM, 32'h10, 2'h0);
    rdchk(ADDR_LOOP, 32'd4016);
    wr(ADDR_CUR_TRIM, 32'h0, 2'h0);
    wr(ADDR_GAIN, 32'h0001_2000, 2'h0);
    wr(ADDR_ZERO, 32'h10, 2'h0);
    wr(ADDR_TEMP_COR, 32'h5, 2'h0);
    rdchk(ADDR_GAIN, 32'h0001_2000);
    wr(ADDR_CMD, 32'h2, 2'h0);
    rdchk(ADDR_ZERO, 32'h0);
    rdchk(ADDR_GAIN, 32'h0001_0000);
    rdchk(ADDR_TEMP_COR, 32'h0);
    wr(ADDR_CTRL, 32'h2, 2'h0);
    wr(ADDR_GAIN, 32'h0001_1000, 2'h2);
    wr(ADDR_ZERO, 32'h0, 2'h0);
    wr(ADDR_CTRL, 32'h0960, 2'h0);
    rdchk(ADDR_CTRL, 32'h0900);
    wr(ADDR_CTRL, 32'h0961, 2'h0);
    rdchk(ADDR_CTRL, 32'h0961);
    settle(12000, 0);
    settle(2000, 0);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CTRL, dctl[k], 2'h0);
      seen = 16'h0;
      repeat (18000) @(posedge clk) seen[display_var] = 1'b1;
      check(seen, dmask[k]);
    end
    wr(ADDR_ALM1_LIM, 32'd5000, 2'h0);
    wr(ADDR_ALM2_LIM, 32'd9000, 2'h0);
    wr(ADDR_ALM_CFG, 32'h25, 2'h0);
    foreach (dctl[k]) begin
      v = k == 0 ? 7000 : k == 1 ? 4000 : 10000;
      @(posedge clk);
      sensor_in <= v;
      poll(ADDR_PV, v);
      @(negedge clk);
      check(alarm_active, k == 0 ? 3'h0 : k == 1 ? 3'h2 : 3'h4);
    end
    check(ack_pending, 1'b1);
    wr(ADDR_CMD, 32'h1, 2'h0);
    rdchk(ADDR_STATUS, 32'h4);
    @(posedge clk);
    burnout <= 1'b1;
    poll(ADDR_STATUS, 32'hd);
    wr(ADDR_ALM_CFG, 32'h0, 2'h0);
    rdchk(ADDR_LRV, 32'd12000);
    check(alarm_active, 3'h0);
    stop_test();
  end
endmodule
